// [core/msi_consts.vh]
// Purpose: Constants for the status and interrupt unit
// Assumes: Register bus addresses are data memory locations
// Notes: Definitions only
`ifndef MSI_CONSTS_VH
`define MSI_CONSTS_VH
// Register offsets
`define MSI_ADDR_FLAGS 8'h0a
`define MSI_ADDR_INTERRUPT_CONTROL 8'h0b
`define MSI_ADDR_EPSTAT 8'h1b
`define MSI_ADDR_USBCS 8'h1a
// Status bit positions
`define MSI_F_CARRY 0
`define MSI_F_HALF 1
`define MSI_F_ZERO 2
`define MSI_F_WRAP 3
`define MSI_F_SLEEP 4
`define MSI_F_WDOG 5
// Interrupt control bit positions
`define MSI_I_GIE 0
`define MSI_I_UEN 1
`define MSI_I_T0EN 2
`define MSI_I_T1EN 3
`define MSI_I_UPND 4
`define MSI_I_T0PND 5
`define MSI_I_T1PND 6
// USB control/status bit positions
`define MSI_U_SUSPEND 0
`define MSI_U_BUSRST 2
`define MSI_U_RESUME 3
// Writable masks
`define MSI_FLAGS_WMASK 8'h0f
`define MSI_INTERRUPT_CONTROL_WMASK 8'h7f
// Reset values
`define MSI_FLAGS_RST 8'h00
`define MSI_INTERRUPT_CONTROL_RST 8'h00
`define MSI_EP_RST 8'h00
`define MSI_UCS_RST 8'h00
// Vectors
`define MSI_VEC_USB 12'h004
`define MSI_VEC_T0 12'h008
`define MSI_VEC_T1 12'h00c
`endif

// [core/msi_unit.v]
// Purpose: Processor flags and interrupt control of an 8-bit core
// Assumes: Core sequencer drives ALU results, instruction pulses, stack state
// Notes: Event inputs from the core share clk_sys; no synchronisers
//
// The address-and-strobe port was left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "msi_consts.vh"
module msi_unit (
   // Clock and reset
   input wire clk_sys,
   input wire rst,
   // Register port
   input wire [7:0] reg_addr,
   input wire [7:0] reg_wdata,
   input wire reg_wr,
   input wire reg_rd,
   output reg [7:0] reg_rdata,
   // ALU results
   input wire alu_valid,
   input wire alu_arith,
   input wire alu_sub,
   input wire [7:0] alu_a,
   input wire [7:0] alu_b,
   input wire alu_cin,
   input wire [7:0] alu_result,
   input wire rot_valid,
   input wire rot_carry,
   // Instruction events
   input wire halt_instr,
   input wire watchdog_clear_instr,
   input wire watchdog_timeout,
   input wire interrupt_exit_instr,
   input wire subroutine_exit_instr,
   // Sequencer handshake
   input wire irq_sample_phase,
   input wire stack_full,
   // Interrupt sources
   input wire [2:0] ep_fifo_access,
   input wire usb_suspend,
   input wire usb_resume,
   input wire usb_bus_reset,
   input wire timer0_overflow,
   input wire timer1_overflow,
   // Core outputs
   output reg irq_call,
   output reg [11:0] irq_vector,
   output reg [7:0] processor_flags,
   output reg [7:0] interrupt_control,
   output reg [7:0] endpoint_access_status,
   output reg [7:0] usb_ctrl_status_reg
);

   // ----------------------------------------
   // Helpers
   // ----------------------------------------
   function sel;
      input [7:0] a;
      input [7:0] b;
      begin
         sel = (a == b);
      end
   endfunction

   // Lowest index wins: USB, then timer 0, then timer 1
   function [2:0] pick_first;
      input [2:0] req;
      begin
         pick_first = 3'b000;
         if (req[0])
            pick_first = 3'b001;
         else if (req[1])
            pick_first = 3'b010;
         else if (req[2])
            pick_first = 3'b100;
      end
   endfunction

   // ----------------------------------------
   // Write decode
   // ----------------------------------------
   // Decoded once so every register sees one strobe
   wire wr_flags = reg_wr && sel(reg_addr, `MSI_ADDR_FLAGS);
   wire wr_interrupt_control = reg_wr && sel(reg_addr, `MSI_ADDR_INTERRUPT_CONTROL);
   wire wr_ep = reg_wr && sel(reg_addr, `MSI_ADDR_EPSTAT);
   wire wr_ucs = reg_wr && sel(reg_addr, `MSI_ADDR_USBCS);

   // ----------------------------------------
   // ALU flag computation
   // ----------------------------------------
   // Subtraction is a + ~b + cin; carry out then means no borrow
   wire [7:0] op_b = alu_sub ? ~alu_b : alu_b;
   wire [4:0] lo_sum = {1'b0, alu_a[3:0]} + {1'b0, op_b[3:0]} + {4'h0, alu_cin};
   wire [7:0] lo7_sum = {1'b0, alu_a[6:0]} + {1'b0, op_b[6:0]} + {7'h00, alu_cin};
   wire [8:0] full_sum = {1'b0, alu_a} + {1'b0, op_b} + {8'h00, alu_cin};
   wire c_out = full_sum[8];
   wire h_out = lo_sum[4];
   wire v_out = lo7_sum[7] ^ full_sum[8];
   wire z_out = (alu_result == 8'h00);

   // ----------------------------------------
   // Flag next state
   // ----------------------------------------
   // Later terms win: instruction effects beat a bus write
   reg [7:0] next_flags;
   always @*
   begin
      next_flags = processor_flags;
      if (wr_flags)
      begin
         // Sleep and watchdog flags never taken from the bus
         next_flags = (next_flags & ~`MSI_FLAGS_WMASK) | (reg_wdata & `MSI_FLAGS_WMASK);
      end
      if (alu_valid)
      begin
         next_flags[`MSI_F_ZERO] = z_out;
         if (alu_arith)
         begin
            next_flags[`MSI_F_CARRY] = c_out;
            next_flags[`MSI_F_HALF] = h_out;
            next_flags[`MSI_F_WRAP] = v_out;
         end
      end
      if (rot_valid)
      begin
         next_flags[`MSI_F_CARRY] = rot_carry;
      end
      if (watchdog_clear_instr)
      begin
         next_flags[`MSI_F_SLEEP] = 1'b0;
         next_flags[`MSI_F_WDOG] = 1'b0;
      end
      if (halt_instr)
      begin
         next_flags[`MSI_F_SLEEP] = 1'b1;
         next_flags[`MSI_F_WDOG] = 1'b0;
      end
      if (watchdog_timeout)
      begin
         next_flags[`MSI_F_WDOG] = 1'b1;
      end
      next_flags[7:6] = 2'b00;
   end

   // ----------------------------------------
   // Interrupt arbitration
   // ----------------------------------------
   wire usb_event = (|ep_fifo_access) | usb_suspend | usb_resume | usb_bus_reset;
   wire usb_go = interrupt_control[`MSI_I_UEN] & interrupt_control[`MSI_I_UPND];
   wire t0_go = interrupt_control[`MSI_I_T0EN] & interrupt_control[`MSI_I_T0PND];
   wire t1_go = interrupt_control[`MSI_I_T1EN] & interrupt_control[`MSI_I_T1PND];
   // Full stack blocks acknowledge; pending flags are kept
   wire take = irq_sample_phase & interrupt_control[`MSI_I_GIE] & ~stack_full
      & (usb_go | t0_go | t1_go);
   wire [2:0] win = pick_first({t1_go, t0_go, usb_go});
   wire take_usb = take & win[0];
   wire take_t0 = take & win[1];
   wire take_t1 = take & win[2];

   reg [7:0] next_interrupt_control;
   always @*
   begin
      next_interrupt_control = interrupt_control;
      if (wr_interrupt_control)
      begin
         next_interrupt_control = reg_wdata & `MSI_INTERRUPT_CONTROL_WMASK;
      end
      if (interrupt_exit_instr)
      begin
         next_interrupt_control[`MSI_I_GIE] = 1'b1;
      end
      if (take)
      begin
         next_interrupt_control[`MSI_I_GIE] = 1'b0;
      end
      if (take_usb)
      begin
         next_interrupt_control[`MSI_I_UPND] = 1'b0;
      end
      if (take_t0)
      begin
         next_interrupt_control[`MSI_I_T0PND] = 1'b0;
      end
      if (take_t1)
      begin
         next_interrupt_control[`MSI_I_T1PND] = 1'b0;
      end
      // New events win over any clear in the same cycle
      if (usb_event)
      begin
         next_interrupt_control[`MSI_I_UPND] = 1'b1;
      end
      if (timer0_overflow)
      begin
         next_interrupt_control[`MSI_I_T0PND] = 1'b1;
      end
      if (timer1_overflow)
      begin
         next_interrupt_control[`MSI_I_T1PND] = 1'b1;
      end
      next_interrupt_control[7] = 1'b0;
   end

   // ----------------------------------------
   // Endpoint access status
   // ----------------------------------------
   // Host access beats a same-cycle firmware clear
   wire [7:0] ep_base = wr_ep ? reg_wdata : endpoint_access_status;
   wire [7:0] ep_merged;
   genvar gi;
   generate
      for (gi = 0; gi < 8; gi = gi + 1)
      begin : g_ep
         if (gi < 3)
         begin : g_live
            assign ep_merged[gi] = ep_base[gi] | ep_fifo_access[gi];
         end
         else
         begin : g_spare
            assign ep_merged[gi] = ep_base[gi];
         end
      end
   endgenerate

   reg [7:0] next_ep;
   always @*
   begin
      next_ep = ep_merged;
   end

   // ----------------------------------------
   // USB control and status
   // ----------------------------------------
   reg [7:0] next_ucs;
   always @*
   begin
      next_ucs = usb_ctrl_status_reg;
      if (wr_ucs)
      begin
         next_ucs = reg_wdata;
      end
      if (usb_suspend)
      begin
         next_ucs[`MSI_U_SUSPEND] = 1'b1;
      end
      if (usb_resume)
      begin
         next_ucs[`MSI_U_RESUME] = 1'b1;
      end
      if (usb_bus_reset)
      begin
         next_ucs[`MSI_U_BUSRST] = 1'b1;
      end
   end

   // ----------------------------------------
   // Flag and control registers
   // ----------------------------------------
   always @(posedge clk_sys)
   begin
      if (rst)
      begin
         processor_flags <= `MSI_FLAGS_RST;
         interrupt_control <= `MSI_INTERRUPT_CONTROL_RST;
      end
      else
      begin
         processor_flags <= next_flags;
         interrupt_control <= next_interrupt_control;
      end
   end

   // ----------------------------------------
   // USB status state
   // ----------------------------------------
   always @(posedge clk_sys)
   begin
      if (rst)
      begin
         endpoint_access_status <= `MSI_EP_RST;
         usb_ctrl_status_reg <= `MSI_UCS_RST;
      end
      else
      begin
         endpoint_access_status <= next_ep;
         usb_ctrl_status_reg <= next_ucs;
      end
   end

   // ----------------------------------------
   // Call outputs
   // ----------------------------------------
   // Vector holds between calls so the core may fetch it late
   always @(posedge clk_sys)
   begin
      if (rst)
      begin
         irq_call <= 1'b0;
         irq_vector <= 12'h000;
      end
      else
      begin
         // Call pulse only; the core pushes just its program counter
         irq_call <= take;
         if (take_usb)
         begin
            irq_vector <= `MSI_VEC_USB;
         end
         else if (take_t0)
         begin
            irq_vector <= `MSI_VEC_T0;
         end
         else if (take_t1)
         begin
            irq_vector <= `MSI_VEC_T1;
         end
      end
   end

   // ----------------------------------------
   // Read port
   // ----------------------------------------
   // Idle cycles return zero so a shared bus needs no gating
   always @(posedge clk_sys)
   begin
      if (rst)
      begin
         reg_rdata <= 8'h00;
      end
      else
      begin
         reg_rdata <= 8'h00;
         if (reg_rd)
         begin
            case (reg_addr)
               `MSI_ADDR_FLAGS: reg_rdata <= processor_flags;
               `MSI_ADDR_INTERRUPT_CONTROL: reg_rdata <= interrupt_control;
               `MSI_ADDR_EPSTAT: reg_rdata <= endpoint_access_status;
               `MSI_ADDR_USBCS: reg_rdata <= usb_ctrl_status_reg;
               default: reg_rdata <= 8'h00;
            endcase
         end
      end
   end

endmodule // msi_unit
`default_nettype wire

// [dv/msi_core_model.sv]
// Purpose: Core sequencer and return stack model
// Assumes: One sample phase every four clocks
// Notes: Depth is a parameter so a full stack comes quickly
`timescale 1ns/1ps
`default_nettype none
module msi_core_model #(parameter int DEPTH = 8) (
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic irq_call,
   input wire logic ret,
   output logic irq_sample_phase,
   output logic stack_full
);
   logic [1:0] phase;
   int level;
   always @(posedge clk_sys)
   begin
      if (rst)
      begin
         phase <= 2'h0;
         level <= 0;
      end
      else
      begin
         phase <= phase + 2'h1;
         // Return address only, flags never stacked
         level <= level + int'(irq_call) - int'(ret && level > 0);
      end
   end
   assign irq_sample_phase = (phase == 2'h3);
   assign stack_full = (level >= DEPTH);
endmodule // msi_core_model
`default_nettype wire

// [dv/msi_unit_monitor.sv]
// Purpose: Port assertions for the status and interrupt unit
// Assumes: Bound into msi_unit
// Notes: Reset disables every check
`timescale 1ns/1ps
`default_nettype none
module msi_unit_monitor (
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic alu_valid,
   input wire logic [7:0] alu_result,
   input wire logic halt_instr,
   input wire logic watchdog_clear_instr,
   input wire logic watchdog_timeout,
   input wire logic irq_sample_phase,
   input wire logic stack_full,
   input wire logic irq_call,
   input wire logic [11:0] irq_vector,
   input wire logic [7:0] processor_flags,
   input wire logic [7:0] interrupt_control
);
   default clocking @(posedge clk_sys); endclocking
   default disable iff (rst);
   a_flags_top: assert property (processor_flags[7:6] == 2'b00) else $error("flag top bits");
   a_interrupt_control_top: assert property (!interrupt_control[7]) else $error("interrupt_control bit 7");
   a_call_gate: assert property (irq_call |-> !$past(stack_full) && $past(irq_sample_phase))
      else $error("call while full or off phase");
   a_call_gie: assert property (irq_call |-> $past(interrupt_control[0]) && !interrupt_control[0])
      else $error("call without global enable");
   a_usb_first: assert property (irq_call && $past(interrupt_control[1] && interrupt_control[4])
      |-> irq_vector == 12'h004 && !interrupt_control[4]) else $error("usb not first");
   a_halt_flags: assert property (halt_instr && !watchdog_timeout |=> processor_flags[5:4] == 2'b01)
      else $error("halt flags");
   a_sleep_keep: assert property (!halt_instr && !watchdog_clear_instr |=> $stable(processor_flags[4]))
      else $error("sleep flag moved");
   a_zero_flag: assert property (alu_valid |=> processor_flags[2] == ($past(alu_result) == 8'h00))
      else $error("zero flag");
endmodule // msi_unit_monitor
bind msi_unit msi_unit_monitor i_mon (.*);
`default_nettype wire

// [dv/tb.sv]
// Purpose: Self-checking bench for the status and interrupt unit
// Assumes: Core model with a two-deep stack
// Notes: Random ALU operands from a fixed seed
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin n_fail++; $display("Error t=%0t got %h exp %h", $time, g, e); end end
module tb;
   logic clk_sys = 1'b0;
   logic rst = 1'b1;
   logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata, a = 8'h00, b = 8'h00, res = 8'h00;
   logic reg_wr = 1'b0, reg_rd = 1'b0, alu_valid = 1'b0, sub = 1'b0, cin = 1'b0, rot_valid = 1'b0, rot_c = 1'b0;
   logic [12:0] ev = 13'h0000;
   logic irq_call, ph, sf, arith_op = 1'b1;
   logic [7:0] fl_o, ic_o, ep_o, uc_o;
   logic [11:0] irq_vector;
   int n_fail = 0, n_tests = 0;
   always #10 clk_sys = ~clk_sys;
   msi_unit i_dut (.clk_sys(clk_sys), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
      .reg_rd(reg_rd), .reg_rdata(reg_rdata), .alu_valid(alu_valid), .alu_arith(arith_op), .alu_sub(sub), .alu_a(a),
      .alu_b(b), .alu_cin(cin), .alu_result(res), .rot_valid(rot_valid), .rot_carry(rot_c), .halt_instr(ev[12]),
      .watchdog_clear_instr(ev[11]), .watchdog_timeout(ev[10]), .interrupt_exit_instr(ev[9]),
      .subroutine_exit_instr(ev[8]), .irq_sample_phase(ph), .stack_full(sf), .ep_fifo_access(ev[7:5]),
      .usb_suspend(ev[4]), .usb_resume(ev[3]), .usb_bus_reset(ev[2]), .timer0_overflow(ev[1]),
      .timer1_overflow(ev[0]), .irq_call(irq_call), .irq_vector(irq_vector), .processor_flags(fl_o),
      .interrupt_control(ic_o), .endpoint_access_status(ep_o), .usb_ctrl_status_reg(uc_o));
   msi_core_model #(.DEPTH(2)) i_core (.clk_sys(clk_sys), .rst(rst), .irq_call(irq_call), .ret(ev[9] | ev[8]),
      .irq_sample_phase(ph), .stack_full(sf));
   function automatic logic [3:0] arith(input logic [7:0] x, y, input logic s, c);
      logic [7:0] yy, m;
      logic [8:0] f;
      logic [4:0] lo;
      yy = s ? ~y : y;
      f = {1'b0, x} + {1'b0, yy} + 9'(c);
      lo = {1'b0, x[3:0]} + {1'b0, yy[3:0]} + 5'(c);
      m = {1'b0, x[6:0]} + {1'b0, yy[6:0]} + 8'(c);
      return {m[7] ^ f[8], f[7:0] == 8'h00, lo[4], f[8]};
   endfunction
   task automatic conclude();
      $display("tests %0d fails %0d", n_tests, n_fail);
      if (n_fail == 0 && n_tests > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask
   task automatic wr(input logic [7:0] ad, d);
      @(posedge clk_sys);
      reg_addr <= ad;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge clk_sys);
      reg_wr <= 1'b0;
   endtask
   task automatic rdc(input logic [7:0] ad, e, m);
      @(posedge clk_sys);
      reg_addr <= ad;
      reg_rd <= 1'b1;
      @(posedge clk_sys);
      reg_rd <= 1'b0;
      #1;
      `CHK(reg_rdata & m, e)
   endtask
   task automatic pulse(input logic [12:0] m);
      @(posedge clk_sys);
      ev <= m;
      @(posedge clk_sys);
      ev <= 13'h0000;
   endtask
   task automatic wait_call(input logic [11:0] v);
      int i;
      #1;
      for (i = 0; i < 40 && irq_call !== 1'b1; i++)
      begin
         @(posedge clk_sys);
         #1;
      end
      `CHK({irq_call, irq_vector}, {1'b1, v})
      if (i == 40)
         conclude();
   endtask
   initial
   begin
      logic [12:0] fev[5] = '{13'h1000, 13'h0400, 13'h0800, 13'h0400, 13'h1000};
      logic [7:0] fex[5] = '{8'h10, 8'h30, 8'h00, 8'h20, 8'h10};
      logic [7:0] iex[3] = '{8'h6e, 8'h4e, 8'h0e};
      logic [7:0] x, y, rv;
      logic s, c, r;
      int i;
      void'($urandom(32'h4f6288e5));
      repeat (6) @(posedge clk_sys);
      rst <= 1'b0;
      rdc(8'h0a, 8'h00, 8'hff);
      rdc(8'h0b, 8'h00, 8'hff);
      rdc(8'h30, 8'h00, 8'hff);
      wr(8'h0a, 8'hff);
      rdc(8'h0a, 8'h0f, 8'hff);
      `CHK(fl_o, 8'h0f)
      wr(8'h0b, 8'hf0);
      rdc(8'h0b, 8'h70, 8'hff);
      wr(8'h0b, 8'h00);
      $display("registers done");
      for (i = 0; i < 24; i++)
      begin
         x = (i == 0) ? 8'h7f : (i == 1) ? 8'h00 : (i == 2) ? 8'h0f : 8'($urandom);
         y = (i == 0) ? 8'h01 : (i == 1) ? 8'h00 : (i == 2) ? 8'hf0 : 8'($urandom);
         s = (i == 1) ? 1'b1 : (i == 0) ? 1'b0 : 1'($urandom);
         c = (i == 1) ? 1'b1 : (i == 0) ? 1'b0 : 1'($urandom);
         r = (i < 2) ? 1'b1 : (i == 2) ? 1'b0 : 1'($urandom);
         rv = r ? 8'(x + (s ? ~y : y) + 8'(c)) : (x & y);
         @(posedge clk_sys);
         {a, b, sub, cin, alu_valid, arith_op} <= {x, y, s, c, 1'b1, r};
         res <= rv;
         @(posedge clk_sys);
         alu_valid <= 1'b0;
         if (r)
            rdc(8'h0a, {4'h0, arith(x, y, s, c)}, 8'h0f);
         else
            rdc(8'h0a, {5'h00, rv == 8'h00, 2'h0}, 8'h04);
         rot_c <= ~c;
         rot_valid <= 1'b1;
         @(posedge clk_sys);
         rot_valid <= 1'b0;
         rdc(8'h0a, {7'h00, ~c}, 8'h01);
      end
      for (i = 0; i < 5; i++)
      begin
         pulse(fev[i]);
         rdc(8'h0a, fex[i], 8'h30);
      end
      $display("flags done");
      wr(8'h0b, 8'h0e);
      pulse(13'h00ff);
      rdc(8'h0b, 8'h7e, 8'hff);
      `CHK({ic_o, uc_o, ep_o}, 24'h7e0d07)
      rdc(8'h1a, 8'h0d, 8'hff);
      rdc(8'h1b, 8'h07, 8'hff);
      wr(8'h1a, 8'h00);
      wr(8'h1b, 8'h00);
      rdc(8'h1a, 8'h00, 8'hff);
      rdc(8'h1b, 8'h00, 8'hff);
      wr(8'h0b, 8'h7f);
      for (i = 0; i < 3; i++)
      begin
         wait_call(12'(4 * (i + 1)));
         rdc(8'h0b, iex[i], 8'hff);
         pulse(13'h0200);
      end
      rdc(8'h0b, 8'h0f, 8'hff);
      $display("priority done");
      wr(8'h0b, 8'h04);
      for (i = 0; i < 3; i++)
      begin
         pulse(13'h0002);
         wr(8'h0b, 8'h25);
         if (i < 2)
            wait_call(12'h008);
      end
      repeat (12)
      begin
         @(posedge clk_sys);
         #1;
         `CHK(irq_call, 1'b0)
      end
      pulse(13'h0100);
      wait_call(12'h008);
      rdc(8'h0b, 8'h04, 8'hff);
      $display("stack done");
      conclude();
   end
endmodule // tb
`default_nettype wire
